/* logic/rmq_regs.vh */
// Constants for the reference monitor qualify configuration bank.
// Assumes one 20 MHz clock; the serial port decodes addresses upstream.
`ifndef RMQ_REGS_VH
`define RMQ_REGS_VH

// ==========================================================
// Register offsets
`define RMQ_OFF_FAIL_MASK  8'h09
`define RMQ_OFF_INPUT_CFG  8'h0A
`define RMQ_OFF_DQ_DELAY   8'h0B
`define RMQ_OFF_Q_DELAY    8'h0C

// ==========================================================
// Reset values
`define RMQ_RST_FAIL_MASK  8'h66
`define RMQ_RST_INPUT_CFG  8'h10
`define RMQ_RST_DQ_DELAY   8'hAA
`define RMQ_RST_Q_DELAY    8'h55

// ==========================================================
// Field layout
`define RMQ_NREF           4
`define RMQ_MASK_W         4
`define RMQ_HALVE_LSB      0
`define RMQ_DIFF_LSB       4
`define RMQ_SEL_W          2
`define RMQ_BIT_LOS        0
`define RMQ_BIT_SCM        1
`define RMQ_BIT_CFM        2
`define RMQ_BIT_GST        3

// ==========================================================
// Timing: 1 ms soak time base
// Sized to the counter width so no assignment drops bits
`define RMQ_CLK_KHZ        15'h4E20
`define RMQ_TICK_MS        15'h0001
`define RMQ_TICK_CYC       (`RMQ_CLK_KHZ * `RMQ_TICK_MS)
`define RMQ_DQ_MIN_MS      15'h0001
`define RMQ_DQ_10_MS       15'h000A
`define RMQ_DQ_50_MS       15'h0032
`define RMQ_DQ_2S5_MS      15'h09C4
`define RMQ_CNT_W          15
`define RMQ_PRE_W          15

`endif

/* logic/rmq_top.v */
// Reference monitor qualify configuration bank and guard soak timers.
// Assumes the serial port logic presents register writes on CLOCK and
// that the failure detectors run on CLOCK; reference pins are async.
//
// Summary of operation
// - References 0 and 1 each have four mask bits: loss, cycle, frequency, soak.
// - Mask bit zero disables an indicator, one leaves it enabled.
// - Masking only affects the interrupt status at address 0x02.
// - Sticky failure register at 0x07 always reports unmasked failures.
// - Halve enable high divides reference by two before tracking loop.
// - Differential select high uses both pins, low only positive pin.
// - Disqualify after cycle or frequency failure: min, 10ms, 50ms, 2.5s.
// - Requalify after 2, 4, 6 or 8 times the disqualify delay.
// - Reset defaults: disqualify 50 ms code, qualify four times.
// - Soak failure stands while that reference is disqualified: from reset, and after its disqualify timer expires.
`include "rmq_regs.vh"

module rmq_top #(
  parameter [`RMQ_PRE_W-1:0] TICK_CYCLES = `RMQ_TICK_CYC // Cycles per ms
) (
  input  wire       CLOCK,           // 20 MHz system clock
  input  wire       ARST_N,          // Async reset, active low
  input  wire [7:0] REG_ADDR,        // Register address
  input  wire       REG_WR,          // Write strobe, one cycle
  input  wire [7:0] REG_WDATA,       // Write data
  output reg  [7:0] REG_RDATA,       // Read data, registered
  input  wire [3:0] REF_IN_POSITIVE, // Reference positive pins
  input  wire [3:0] REF_IN_NEGATIVE, // Reference negative pins
  input  wire [3:0] LOS_IND,         // Loss of signal indications
  input  wire [3:0] SCM_IND,         // Single cycle monitor indications
  input  wire [3:0] CFM_IND,         // Coarse frequency indications
  output reg  [3:0] TRACK_REF,       // References to tracking loop
  output reg  [3:0] REF_QUALIFIED,   // Soak qualified per reference
  output reg  [7:0] FAIL_IRQ_STATUS, // Masked failures, refs 0 and 1
  output reg  [7:0] FAIL_STICKY_RAW  // Unmasked failures, refs 0 and 1
);

  // ========================================================
  // Configuration registers
  reg [7:0] fail_mask_r;
  reg [7:0] input_cfg_r;
  reg [7:0] dq_delay_r;
  reg [7:0] q_delay_r;

  // Disqualify delay in soak ticks
  function [`RMQ_CNT_W-1:0] dq_ticks;
    input [1:0] code;
    begin
      case (code)
        2'h0:    dq_ticks = `RMQ_DQ_MIN_MS;
        2'h1:    dq_ticks = `RMQ_DQ_10_MS;
        2'h2:    dq_ticks = `RMQ_DQ_50_MS;
        default: dq_ticks = `RMQ_DQ_2S5_MS;
      endcase
    end
  endfunction

  // Qualify delay: (mult+1)*2 times disqualify delay, max 20000 ticks
  function [`RMQ_CNT_W-1:0] q_ticks;
    input [1:0] mult;
    input [1:0] code;
    reg   [`RMQ_CNT_W-1:0] base;
    begin
      base    = dq_ticks(code);
      q_ticks = base * {{(`RMQ_CNT_W-3){1'b0}}, mult, 1'b0} + (base << 1);
    end
  endfunction

  // Register writes; reset values give 50 ms and 4x soak times
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fail_mask_r <= `RMQ_RST_FAIL_MASK;
      input_cfg_r <= `RMQ_RST_INPUT_CFG;
      dq_delay_r  <= `RMQ_RST_DQ_DELAY;
      q_delay_r   <= `RMQ_RST_Q_DELAY;
    end else if (REG_WR) begin
      case (REG_ADDR)
        `RMQ_OFF_FAIL_MASK: fail_mask_r <= REG_WDATA;
        `RMQ_OFF_INPUT_CFG: input_cfg_r <= REG_WDATA;
        `RMQ_OFF_DQ_DELAY:  dq_delay_r  <= REG_WDATA;
        `RMQ_OFF_Q_DELAY:   q_delay_r   <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Read mux; addresses outside this bank read zero
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      case (REG_ADDR)
        `RMQ_OFF_FAIL_MASK: REG_RDATA <= fail_mask_r;
        `RMQ_OFF_INPUT_CFG: REG_RDATA <= input_cfg_r;
        `RMQ_OFF_DQ_DELAY:  REG_RDATA <= dq_delay_r;
        `RMQ_OFF_Q_DELAY:   REG_RDATA <= q_delay_r;
        default:            REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ========================================================
  // Soak time base: one tick per millisecond
  reg [`RMQ_PRE_W-1:0] pre_cnt_r;
  reg                  tick_r;

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre_cnt_r <= {`RMQ_PRE_W{1'b0}};
      tick_r    <= 1'b0;
    end else if (pre_cnt_r >= TICK_CYCLES - 1'b1) begin
      pre_cnt_r <= {`RMQ_PRE_W{1'b0}};
      tick_r    <= 1'b1;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
      tick_r    <= 1'b0;
    end
  end

  // ========================================================
  // Per-reference input path and guard soak timer
  wire [3:0] gst_fail;
  wire [3:0] trk_nxt;  // Per-reference next tracking level
  wire [3:0] qual_vec; // Per-reference qualified state

  genvar i;
  generate
    for (i = 0; i < `RMQ_NREF; i = i + 1) begin : g_ref
      reg [1:0]            p_sync_r;
      reg [1:0]            n_sync_r;
      reg                  rx_r;
      reg                  rx_d_r;
      reg                  half_r;
      reg                  fail_d_r;
      reg                  qual_r;
      reg [`RMQ_CNT_W-1:0] cnt_r;
      wire                 diff_sel;
      wire                 rx_nxt;
      wire                 fail;
      wire [1:0]           dq_code;
      wire [`RMQ_CNT_W-1:0] limit;
      wire                 soaking;

      assign diff_sel = input_cfg_r[`RMQ_DIFF_LSB + i];
      // Differential holds its level while both pins agree
      assign rx_nxt = diff_sel ?
                      ((p_sync_r[1] != n_sync_r[1]) ? p_sync_r[1] : rx_r) :
                      p_sync_r[1];

      // Pin synchronisers and receiver
      always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          p_sync_r <= 2'b00;
          n_sync_r <= 2'b00;
          rx_r     <= 1'b0;
          rx_d_r   <= 1'b0;
          half_r   <= 1'b0;
        end else begin
          p_sync_r <= {p_sync_r[0], REF_IN_POSITIVE[i]};
          n_sync_r <= {n_sync_r[0], REF_IN_NEGATIVE[i]};
          rx_r     <= rx_nxt;
          rx_d_r   <= rx_r;
          if (rx_r && !rx_d_r)
            half_r <= ~half_r;
        end
      end

      // Halved or straight reference toward the tracking loop
      assign trk_nxt[i] = input_cfg_r[`RMQ_HALVE_LSB + i] ?
                          half_r : rx_r;

      assign fail    = SCM_IND[i] | CFM_IND[i];
      assign dq_code = dq_delay_r[`RMQ_SEL_W*i +: `RMQ_SEL_W];
      // Qualified refs wait out the disqualify time, others the qualify time
      assign limit   = qual_r ? dq_ticks(dq_code) :
                       q_ticks(q_delay_r[`RMQ_SEL_W*i +: `RMQ_SEL_W],
                               dq_code);
      assign soaking = qual_r ? fail : ~fail;

      // Soak counter restarts on every change of the monitor indication
      always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          fail_d_r <= 1'b0;
          qual_r   <= 1'b0;
          cnt_r    <= {`RMQ_CNT_W{1'b0}};
        end else begin
          fail_d_r <= fail;
          if (fail != fail_d_r || !soaking) begin
            cnt_r <= {`RMQ_CNT_W{1'b0}};
          end else if (cnt_r >= limit) begin
            qual_r <= ~qual_r;
            cnt_r  <= {`RMQ_CNT_W{1'b0}};
          end else if (tick_r) begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
      end

      // Soak failure stands while the reference is disqualified
      assign gst_fail[i] = ~qual_r;

      assign qual_vec[i] = qual_r;
    end
  endgenerate

  // One register stage for both vectors, so each has a single driver
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      TRACK_REF     <= 4'h0;
      REF_QUALIFIED <= 4'h0;
    end else begin
      TRACK_REF     <= trk_nxt;
      REF_QUALIFIED <= qual_vec;
    end
  end

  // ========================================================
  // Failure vectors for refs 0 and 1: {gst, cfm, scm, los} per nibble
  wire [7:0] raw_fail;

  generate
    for (i = 0; i < 2; i = i + 1) begin : g_fail
      assign raw_fail[`RMQ_MASK_W*i + `RMQ_BIT_LOS] = LOS_IND[i];
      assign raw_fail[`RMQ_MASK_W*i + `RMQ_BIT_SCM] = SCM_IND[i];
      assign raw_fail[`RMQ_MASK_W*i + `RMQ_BIT_CFM] = CFM_IND[i];
      assign raw_fail[`RMQ_MASK_W*i + `RMQ_BIT_GST] = gst_fail[i];
    end
  endgenerate

  // Mask reaches only the interrupt status path, never the sticky one
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      FAIL_IRQ_STATUS <= 8'h00;
      FAIL_STICKY_RAW <= 8'h00;
    end else begin
      FAIL_IRQ_STATUS <= raw_fail & fail_mask_r;
      FAIL_STICKY_RAW <= raw_fail;
    end
  end

endmodule // rmq_top

/* tb/rmq_chk_checker.sv */
// Port assertions for rmq_top, bound to every instance of it.
// Assumes one-cycle write strobes, each followed by a cycle with
// the strobe low and the address held.
`include "rmq_regs.vh"
// ======================================
// Checker
module rmq_chk (
  input wire       CLOCK,           // Clock
  input wire       ARST_N,          // Reset
  input wire [7:0] REG_ADDR,        // Address
  input wire       REG_WR,          // Write strobe
  input wire [7:0] REG_WDATA,       // Write data
  input wire [7:0] REG_RDATA,       // Read data
  input wire [3:0] LOS_IND,         // Loss levels
  input wire [3:0] SCM_IND,         // Cycle levels
  input wire [3:0] CFM_IND,         // Frequency levels
  input wire [3:0] REF_QUALIFIED,   // Qualified levels
  input wire [7:0] FAIL_IRQ_STATUS, // Masked failures
  input wire [7:0] FAIL_STICKY_RAW  // Unmasked failures
);
  reg  [7:0] msk_r; // Shadow of the mask byte
  wire       in_map;
  wire       fail0;
  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // Decode and failure terms shared by the properties
  assign in_map = (REG_ADDR >= `RMQ_OFF_FAIL_MASK) &&
                  (REG_ADDR <= `RMQ_OFF_Q_DELAY);
  assign fail0  = SCM_IND[0] | CFM_IND[0];
  // Shadow lets the masked vector be predicted from the raw one
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N)
      msk_r <= `RMQ_RST_FAIL_MASK;
    else if (REG_WR && (REG_ADDR == `RMQ_OFF_FAIL_MASK))
      msk_r <= REG_WDATA;
  end
  AST_RD_BACK: assert property (
    REG_WR && in_map ##1 !REG_WR && $stable(REG_ADDR)
    |=> REG_RDATA == $past(REG_WDATA, 2)) else $error("readback differs");
  AST_RD_UNMAP: assert property (
    !in_map && $stable(REG_ADDR) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_IRQ_MASKED: assert property (
    msk_r == $past(msk_r, 2) |-> FAIL_IRQ_STATUS == (FAIL_STICKY_RAW & msk_r))
    else $error("masked vector wrong");
  AST_IRQ_SUBSET: assert property (
    (FAIL_IRQ_STATUS & ~FAIL_STICKY_RAW) == 8'h00)
    else $error("masked bit without raw bit");
  AST_RAW_LOS: assert property (
    $rose(LOS_IND[1]) |-> ##[1:3] FAIL_STICKY_RAW[4])
    else $error("raw loss bit missing");
  AST_DQ_HELD: assert property (
    $fell(REF_QUALIFIED[0]) |-> $past(fail0, 3))
    else $error("disqualified without failure");
  AST_Q_LOW: assert property (
    $rose(REF_QUALIFIED[0]) |-> $past(fail0, 4) == 1'b0)
    else $error("qualified during failure");
  AST_GST_LEVEL: assert property (
    $fell(REF_QUALIFIED[0]) |-> ##[0:2] FAIL_STICKY_RAW[3])
    else $error("soak bit not raised");
endmodule // rmq_chk

bind rmq_top rmq_chk rmq_chk_inst (.CLOCK(CLOCK), .ARST_N(ARST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .LOS_IND(LOS_IND), .SCM_IND(SCM_IND),
  .CFM_IND(CFM_IND), .REF_QUALIFIED(REF_QUALIFIED),
  .FAIL_IRQ_STATUS(FAIL_IRQ_STATUS), .FAIL_STICKY_RAW(FAIL_STICKY_RAW));

/* tb/rmq_host.sv */
// Host model that writes and reads the bank over its register port.
// Assumes the bank samples on the rising clock edge.
// ======================================
// Host
module rmq_host (
  input  wire       clk,   // System clock
  input  wire [7:0] rdata, // Read data
  output logic [7:0] addr, // Address
  output logic      wr,    // Write strobe
  output logic [7:0] wdata // Write data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr  = 8'h00;
    wr    = 1'b0;
    wdata = 8'h00;
  end
  // Strobe for one edge; data inverted after so it cannot linger
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(posedge clk);
    #1;
    wr    = 1'b0;
    wdata = ~d;
  endtask
  // Read data is registered, so wait two edges before taking it
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    repeat (2) @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule // rmq_host

/* tb/ref_monitor_qualify_config_tb.sv */
// Self-checking bench for rmq_top: registers, masking, pins, soak.
// Assumes a 20 MHz clock and a soak tick shortened to 4 cycles.
`include "rmq_regs.vh"
// ======================================
// Bench
module ref_monitor_qualify_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [14:0] TICK = 15'h4; // Short tick keeps the run brief
  logic       clk, arst_n, wr;
  logic [7:0] addr, wdata, rdata, irq, raw, v;
  logic [3:0] pos, neg, los, scm, cfm, trk, qual, trk_q;
  logic [7:0] offs [4] = '{`RMQ_OFF_FAIL_MASK, `RMQ_OFF_INPUT_CFG,
                           `RMQ_OFF_DQ_DELAY, `RMQ_OFF_Q_DELAY};
  logic [7:0] rsts [4] = '{`RMQ_RST_FAIL_MASK, `RMQ_RST_INPUT_CFG,
                           `RMQ_RST_DQ_DELAY, `RMQ_RST_Q_DELAY};
  int         bad_count = 0, cmp_count = 0, rise [4] = '{0, 0, 0, 0};
  rmq_top #(.TICK_CYCLES(TICK)) rmq_top_inst (.CLOCK(clk),
    .ARST_N(arst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REF_IN_POSITIVE(pos), .REF_IN_NEGATIVE(neg),
    .LOS_IND(los), .SCM_IND(scm), .CFM_IND(cfm), .TRACK_REF(trk),
    .REF_QUALIFIED(qual), .FAIL_IRQ_STATUS(irq), .FAIL_STICKY_RAW(raw));
  rmq_host rmq_host_inst (.clk(clk), .rdata(rdata), .addr(addr),
    .wr(wr), .wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Rising edges seen toward the tracking loop, per reference
  always @(posedge clk) begin
    trk_q <= trk;
    for (int i = 0; i < 4; i++)
      if (trk[i] && !trk_q[i]) rise[i] <= rise[i] + 1;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Ref1 differential with inverse on its negative pin, others grounded
  task pulse(input int n);
    repeat (n) begin
      pos = 4'hF;
      neg = 4'h0;
      cyc(4);
      pos = 4'h0;
      neg = 4'h2;
      cyc(4);
    end
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  initial begin
    {arst_n, pos, neg, los, scm, cfm} = 21'h0;
    cyc(5);
    arst_n = 1'b1;
    // Reset values, write and read back, then an unmapped place
    for (int i = 0; i < 4; i++) begin
      rmq_host_inst.rd_reg(offs[i], v);
      check(v, rsts[i], "reset value");
      rmq_host_inst.wr_reg(offs[i], 8'hC3 ^ i[7:0]);
      rmq_host_inst.rd_reg(offs[i], v);
      check(v, 8'hC3 ^ i[7:0], "readback");
    end
    rmq_host_inst.rd_reg(8'h0D, v);
    check(v, 8'h00, "unmapped read");
    // Loss on ref1 with its loss bit masked, then unmasked
    rmq_host_inst.wr_reg(`RMQ_OFF_FAIL_MASK, 8'h66);
    los = 4'h2;
    cyc(4);
    check(raw & 8'h10, 8'h10, "raw loss");
    check(irq & 8'h10, 8'h00, "masked loss");
    rmq_host_inst.wr_reg(`RMQ_OFF_FAIL_MASK, 8'h77);
    cyc(3);
    check(irq & 8'h10, 8'h10, "unmasked loss");
    // Ref0 halved, ref1 differential, ref2 and ref3 straight
    rmq_host_inst.wr_reg(`RMQ_OFF_INPUT_CFG, 8'h21);
    pulse(4);
    cyc(8);
    check(rise[0][7:0], 8'h02, "halved edges");
    check(rise[2][7:0], 8'h04, "straight edges");
    check(rise[1][7:0], 8'h04, "differential edges");
    pos = 4'h6;
    neg = 4'h2;
    cyc(8);
    check(trk & 8'h06, 8'h04, "equal pins hold");
    // Ref0: disqualify 10 ticks, qualify twice that
    rmq_host_inst.wr_reg(`RMQ_OFF_DQ_DELAY, 8'hA9);
    rmq_host_inst.wr_reg(`RMQ_OFF_Q_DELAY, 8'h54);
    // Long failure so ref0 ends disqualified whatever its state was
    scm[0] = 1'b1;
    cyc(60);
    check(qual & 8'h01, 8'h00, "held failure");
    scm[0] = 1'b0;
    cyc(72);
    check(qual & 8'h01, 8'h00, "early qualify");
    cyc(18);
    check(qual & 8'h01, 8'h01, "qualify");
    cfm[0] = 1'b1;
    cyc(32);
    check(qual & 8'h01, 8'h01, "early disqualify");
    cyc(18);
    check(qual & 8'h01, 8'h00, "disqualify");
    check(raw & 8'h08, 8'h08, "soak failure");
    summarize;
  end
endmodule // ref_monitor_qualify_config_tb
